/* logic/two_wire_map.svh */
// Purpose: Register offsets, field positions, reset values and status codes
// Assumes: Included by its bare name from the two-wire design files
// Notes: Definitions only
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_AW 3
`define OFS_CTRL 3'h0
`define OFS_STATUS 3'h1
`define OFS_DATA 3'h2
`define OFS_OWN_ADDR 3'h3
`define OFS_RATE 3'h4
`define OFS_IRQ_STAT 3'h5
`define OFS_IRQ_MASK 3'h6

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_FLAG 7
`define CTRL_ACK 6
`define CTRL_STA 5
`define CTRL_STO 4
`define CTRL_WCOL 3
`define CTRL_EN 2
`define CTRL_IE 0

// ----------------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------------
`define IRQ_W 3
`define IRQ_JOB 0
`define IRQ_ARB 1
`define IRQ_STOP 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DATA_RST 8'hFF
`define OWN_ADDR_RST 8'hFE
`define STATUS_RST 8'hF8

// ----------------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------------
`define ST_START 8'h08
`define ST_REP_START 8'h10
`define ST_W_ADDR_ACK 8'h18
`define ST_W_ADDR_NACK 8'h20
`define ST_W_DATA_ACK 8'h28
`define ST_W_DATA_NACK 8'h30
`define ST_ARB_LOST 8'h38
`define ST_R_ADDR_ACK 8'h40
`define ST_R_ADDR_NACK 8'h48
`define ST_R_DATA_ACK 8'h50
`define ST_R_DATA_NACK 8'h58
`define ST_IDLE 8'hF8

// ----------------------------------------------------------------------
// Bit counts
// ----------------------------------------------------------------------
`define ACK_BIT 4'h8
`define LAST_DATA_BIT 4'h7

`endif

/* logic/two_wire_pkg.sv */
// Purpose: Types shared by the two-wire master
// Assumes: Nothing
// Notes: Engine states only
package two_wire_pkg;

  typedef enum logic [3:0] {
    idle_s,
    start_hold_s,
    pause_s,
    bit_low_s,
    bit_high_s,
    rs_low_s,
    rs_high_s,
    stop_low_s,
    stop_high_s,
    stop_end_s
  } engine_state_t;

endpackage

/* logic/pin_sync.sv */
// Purpose: Three-flop synchroniser with agreement filter for pin inputs
// Assumes: Inputs asynchronous to mclk
// Notes: Output follows once the second and third flops agree
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int W = 2,
  parameter logic [1:0] RST = 2'h3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Pins in, filtered levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  if (W != 2) begin : g_chk
    $error("pin_sync supports W of 2 only");
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        q[i] <= RST[i];
      end else if (ce && (s2_q[i] == s3_q[i])) begin
        q[i] <= s3_q[i];
      end
    end
  end

endmodule

`default_nettype wire

/* logic/two_wire_master_receiver.sv */
// Purpose: Two-wire bus master (receiver, with address/transmit support)
// Assumes: mclk 10 MHz; open-drain pins resolved outside
// Notes: Each half bit is the rate register count plus one mclk cycles; the high half starts once scl is seen high
// Notes on behaviour
// - the START condition is put out only once the bus is free
// - after START the flag sets and status reads 08
// - after address and ack sample the flag sets; status 38, 40 or 48
// - each received byte is readable in the data register while flag set
// - the last received byte is answered with not-acknowledge
// - repeated START uses the START value and reports status 10
// - after repeated START bus ownership is kept, no STOP needed
// - own slave address sits in bits 7..1 of the address register
// - runs only while enabled; writing one to the flag clears it
// - serial clock is held low while the flag is set; after arbitration loss the engine goes idle and leaves it released
// - clearing the flag starts the next operation
// - received bytes are acknowledged only when ack enable is one
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "two_wire_map.svh"

module two_wire_master_receiver
  import two_wire_pkg::*;
#(
  parameter int RATE_RST = 50
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Register port
  input wire logic [`REG_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt
  output logic irq,
  // Serial clock pin
  input wire logic scl_seen,
  output logic scl_level,
  output logic scl_oe_n,
  // Serial data pin
  input wire logic sda_seen,
  output logic sda_level,
  output logic sda_oe_n
);

  if (RATE_RST < 4 || RATE_RST > 255) begin : g_chk
    $error("RATE_RST must lie in 4..255");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  engine_state_t state_q;
  logic [7:0] cnt_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic drv_scl_q;
  logic drv_sda_q;
  logic rx_mode_q;
  logic addr_phase_q;
  logic own_q;
  logic rep_q;
  logic busy_q;
  logic sda_prev_q;
  logic flag_q;
  logic ack_en_q;
  logic start_req_q;
  logic stop_req_q;
  logic wcol_q;
  logic en_q;
  logic ie_q;
  logic [7:0] status_q;
  logic [7:0] data_q;
  logic [7:0] own_addr_q;
  logic [7:0] rate_q;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_mask_q;
  logic [7:0] rdata_q;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wr_ctrl;
  logic flag_set;
  logic arb_lost;
  logic stop_done;
  logic [7:0] status_d;
  logic cnt_done;
  logic [7:0] ctrl_rd;

  assign wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);
  assign cnt_done = (cnt_q == 8'h00);

  // ----------------------------------------------------------------------
  // Pin inputs and outputs
  // ----------------------------------------------------------------------
  pin_sync #(.W(2), .RST(2'h3)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .d({scl_seen, sda_seen}),
    .q(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  assign scl_level = 1'b0;
  assign sda_level = 1'b0;
  assign scl_oe_n = ~drv_scl_q;
  assign sda_oe_n = ~drv_sda_q;

  // ----------------------------------------------------------------------
  // Bus free monitor
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sda_prev_q <= 1'b1;
      busy_q <= 1'b0;
    end else if (ce) begin
      sda_prev_q <= sda_s;
      if (scl_s && sda_prev_q && !sda_s) begin
        busy_q <= 1'b1;
      end else if (scl_s && !sda_prev_q && sda_s) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_q <= 1'b0;
      ack_en_q <= 1'b0;
      start_req_q <= 1'b0;
      stop_req_q <= 1'b0;
      en_q <= 1'b0;
      ie_q <= 1'b0;
    end else if (ce) begin
      if (flag_set) begin
        flag_q <= 1'b1;
      end else if (wr_ctrl && reg_wdata[`CTRL_FLAG]) begin
        flag_q <= 1'b0;
      end
      if (wr_ctrl) begin
        ack_en_q <= reg_wdata[`CTRL_ACK];
        start_req_q <= reg_wdata[`CTRL_STA];
        en_q <= reg_wdata[`CTRL_EN];
        ie_q <= reg_wdata[`CTRL_IE];
      end
      if (stop_done) begin
        stop_req_q <= 1'b0;
      end else if (wr_ctrl) begin
        stop_req_q <= reg_wdata[`CTRL_STO];
      end
    end
  end

  // Reserved bit always reads zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`CTRL_FLAG] = flag_q;
    ctrl_rd[`CTRL_ACK] = ack_en_q;
    ctrl_rd[`CTRL_STA] = start_req_q;
    ctrl_rd[`CTRL_STO] = stop_req_q;
    ctrl_rd[`CTRL_WCOL] = wcol_q;
    ctrl_rd[`CTRL_EN] = en_q;
    ctrl_rd[`CTRL_IE] = ie_q;
  end

  // ----------------------------------------------------------------------
  // Data register and write collision
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      data_q <= `DATA_RST;
      wcol_q <= 1'b0;
    end else if (ce) begin
      if (state_q == bit_high_s && bit_q == `ACK_BIT && cnt_done && scl_s) begin
        data_q <= shift_q;
      end else if (reg_wr && reg_addr == `OFS_DATA) begin
        if (flag_q) begin
          data_q <= reg_wdata;
          wcol_q <= 1'b0;
        end else begin
          wcol_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Plain registers and interrupts
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      own_addr_q <= `OWN_ADDR_RST;
      rate_q <= 8'(RATE_RST);
      irq_mask_q <= '0;
    end else if (ce && reg_wr) begin
      if (reg_addr == `OFS_OWN_ADDR) begin
        own_addr_q <= reg_wdata;
      end
      if (reg_addr == `OFS_RATE) begin
        rate_q <= reg_wdata;
      end
      if (reg_addr == `OFS_IRQ_MASK) begin
        irq_mask_q <= reg_wdata[`IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_stat_q <= '0;
    end else if (ce) begin
      for (int i = 0; i < `IRQ_W; i++) begin
        if ((i == `IRQ_JOB && flag_set) || (i == `IRQ_ARB && arb_lost) ||
            (i == `IRQ_STOP && stop_done)) begin
          irq_stat_q[i] <= 1'b1;
        end else if (reg_wr && reg_addr == `OFS_IRQ_STAT && reg_wdata[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      rdata_q <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          `OFS_CTRL: rdata_q <= ctrl_rd;
          `OFS_STATUS: rdata_q <= status_q;
          `OFS_DATA: rdata_q <= data_q;
          `OFS_OWN_ADDR: rdata_q <= own_addr_q;
          `OFS_RATE: rdata_q <= rate_q;
          `OFS_IRQ_STAT: rdata_q <= {{(8 - `IRQ_W){1'b0}}, irq_stat_q};
          `OFS_IRQ_MASK: rdata_q <= {{(8 - `IRQ_W){1'b0}}, irq_mask_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Status code for the ninth bit
  // ----------------------------------------------------------------------
  always_comb begin
    if (addr_phase_q) begin
      if (rx_mode_q) begin
        status_d = sda_s ? `ST_R_ADDR_NACK : `ST_R_ADDR_ACK;
      end else begin
        status_d = sda_s ? `ST_W_ADDR_NACK : `ST_W_ADDR_ACK;
      end
    end else if (rx_mode_q) begin
      status_d = drv_sda_q ? `ST_R_DATA_ACK : `ST_R_DATA_NACK;
    end else begin
      status_d = sda_s ? `ST_W_DATA_NACK : `ST_W_DATA_ACK;
    end
  end

  assign flag_set = ce && (((state_q == start_hold_s) && cnt_done) ||
    ((state_q == bit_high_s) && cnt_done && scl_s && (bit_q == `ACK_BIT)) || arb_lost);
  assign arb_lost = ce && (state_q == bit_high_s) && cnt_done && scl_s &&
    (bit_q != `ACK_BIT) && (!rx_mode_q || addr_phase_q) && !drv_sda_q && !sda_s;
  assign stop_done = ce && (state_q == stop_end_s) && cnt_done;

  // ----------------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= idle_s;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      drv_scl_q <= 1'b0;
      drv_sda_q <= 1'b0;
      rx_mode_q <= 1'b0;
      addr_phase_q <= 1'b0;
      own_q <= 1'b0;
      rep_q <= 1'b0;
      status_q <= `STATUS_RST;
    end else if (ce) begin
      if (!cnt_done) begin
        cnt_q <= cnt_q - 8'h01;
      end
      if (!en_q) begin
        state_q <= idle_s;
        drv_scl_q <= 1'b0;
        drv_sda_q <= 1'b0;
        own_q <= 1'b0;
      end else begin
        unique case (state_q)
          idle_s: begin
            if (start_req_q && !flag_q && !busy_q && scl_s && sda_s) begin
              drv_sda_q <= 1'b1;
              rep_q <= 1'b0;
              cnt_q <= rate_q;
              state_q <= start_hold_s;
            end
          end
          start_hold_s: begin
            if (cnt_done) begin
              drv_scl_q <= 1'b1;
              own_q <= 1'b1;
              addr_phase_q <= 1'b1;
              status_q <= rep_q ? `ST_REP_START : `ST_START;
              state_q <= pause_s;
            end
          end
          pause_s: begin
            // Clock line stays pulled low until the flag is cleared
            drv_scl_q <= 1'b1;
            cnt_q <= rate_q;
            if (!flag_q) begin
              if (start_req_q) begin
                drv_sda_q <= 1'b0;
                state_q <= rs_low_s;
              end else if (stop_req_q) begin
                drv_sda_q <= 1'b1;
                state_q <= stop_low_s;
              end else begin
                shift_q <= data_q;
                bit_q <= 4'h0;
                if (addr_phase_q) begin
                  rx_mode_q <= data_q[0];
                end
                drv_sda_q <= (addr_phase_q || !rx_mode_q) ? !data_q[7] : 1'b0;
                state_q <= bit_low_s;
              end
            end
          end
          bit_low_s: begin
            if (cnt_done) begin
              drv_scl_q <= 1'b0;
              cnt_q <= rate_q;
              state_q <= bit_high_s;
            end
          end
          bit_high_s: begin
            if (!scl_s) begin
              cnt_q <= rate_q;
            end else if (cnt_done) begin
              cnt_q <= rate_q;
              if (arb_lost) begin
                drv_sda_q <= 1'b0;
                own_q <= 1'b0;
                status_q <= `ST_ARB_LOST;
                state_q <= idle_s;
              end else if (bit_q == `ACK_BIT) begin
                drv_scl_q <= 1'b1;
                status_q <= status_d;
                addr_phase_q <= 1'b0;
                state_q <= pause_s;
              end else begin
                drv_scl_q <= 1'b1;
                shift_q <= {shift_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
                if (bit_q == `LAST_DATA_BIT) begin
                  // Ninth bit: receiver answers, transmitter listens
                  drv_sda_q <= (rx_mode_q && !addr_phase_q) ? ack_en_q : 1'b0;
                end else if (addr_phase_q || !rx_mode_q) begin
                  drv_sda_q <= !shift_q[6];
                end else begin
                  drv_sda_q <= 1'b0;
                end
                state_q <= bit_low_s;
              end
            end
          end
          rs_low_s: begin
            if (cnt_done) begin
              drv_scl_q <= 1'b0;
              cnt_q <= rate_q;
              state_q <= rs_high_s;
            end
          end
          rs_high_s: begin
            if (!scl_s || !sda_s) begin
              cnt_q <= rate_q;
            end else if (cnt_done) begin
              drv_sda_q <= 1'b1;
              rep_q <= 1'b1;
              cnt_q <= rate_q;
              state_q <= start_hold_s;
            end
          end
          stop_low_s: begin
            if (cnt_done) begin
              drv_scl_q <= 1'b0;
              cnt_q <= rate_q;
              state_q <= stop_high_s;
            end
          end
          stop_high_s: begin
            if (!scl_s) begin
              cnt_q <= rate_q;
            end else if (cnt_done) begin
              drv_sda_q <= 1'b0;
              cnt_q <= rate_q;
              state_q <= stop_end_s;
            end
          end
          stop_end_s: begin
            if (cnt_done) begin
              own_q <= 1'b0;
              status_q <= `ST_IDLE;
              state_q <= idle_s;
            end
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* dv/two_wire_master_receiver_properties.sv */
// Purpose: Port-level checks for the two-wire master
// Assumes: Bound to every two_wire_master_receiver instance
// Notes: Enable and mask shadows follow software writes; hold time follows scl_oe_n
`timescale 1ns/10ps
`default_nettype none
`include "two_wire_map.svh"

module two_wire_master_receiver_properties #(
  parameter int RATE_RST = 50
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Register port
  input wire logic [`REG_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  // Pins
  input wire logic scl_seen,
  input wire logic scl_level,
  input wire logic scl_oe_n,
  input wire logic sda_seen,
  input wire logic sda_level,
  input wire logic sda_oe_n
);
  wire logic ctrl_wr = reg_wr && reg_addr == `OFS_CTRL;
  logic en_q;
  logic [2:0] off_q;
  logic [2:0] mask_q;
  logic [8:0] low_q;

  // ----
  // Shadows of enable, mask and clock hold time
  // ----
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      en_q <= 1'b0;
      off_q <= 3'h7;
      mask_q <= 3'h0;
      low_q <= 9'h000;
    end else begin
      if (ctrl_wr) en_q <= reg_wdata[`CTRL_EN];
      off_q <= ctrl_wr ? 3'h0 : (!en_q && off_q != 3'h7) ? off_q + 3'h1 : off_q;
      if (reg_wr && reg_addr == `OFS_IRQ_MASK) mask_q <= reg_wdata[2:0];
      low_q <= (scl_oe_n || ctrl_wr) ? 9'h000 : (low_q == 9'h1FF) ? low_q : low_q + 9'h001;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_off_released: assert property (off_q >= 3'h3 |-> scl_oe_n && sda_oe_n)
    else $error("lines pulled while disabled");
  chk_flag_holds: assert property (low_q > 9'h12C |-> !scl_oe_n)
    else $error("clock released without software");
  chk_clear_resumes: assert property (
    ctrl_wr && reg_wdata[7] && reg_wdata[2] && !scl_oe_n |-> ##[1:300] scl_oe_n)
    else $error("clock not released after flag clear");
  chk_start_free: assert property (
    $fell(sda_oe_n) && scl_oe_n |-> $past(scl_seen) && $past(sda_seen))
    else $error("start on a busy bus");
  chk_status_code: assert property ($past(reg_rd && reg_addr == `OFS_STATUS) |->
    reg_rdata inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40,
    8'h48, 8'h50, 8'h58, 8'hF8})
    else $error("illegal status code");
  chk_ctrl_reserved: assert property (
    $past(reg_rd && reg_addr == `OFS_CTRL) |-> !reg_rdata[1])
    else $error("reserved control bit set");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_irq_masked: assert property (mask_q == 3'h0 |-> !irq)
    else $error("interrupt while all masked");
endmodule

bind two_wire_master_receiver two_wire_master_receiver_properties #(.RATE_RST(RATE_RST)) chk_u (
  .mclk, .resetn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
  .scl_seen, .scl_level, .scl_oe_n, .sda_seen, .sda_level, .sda_oe_n
);
`default_nettype wire

/* dv/two_wire_slave_model.sv */
// Purpose: Behavioural slave transmitter on the two wires
// Assumes: Wires pulled up, so a released line reads high
// Notes: Sends FIRST, FIRST+1 and on until not-acknowledged
`timescale 1ns/10ps
`default_nettype none

module two_wire_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] FIRST = 8'h5C
) (
  // Wires
  input wire logic scl,
  input wire logic sda,
  output logic scl_n,
  output logic sda_n,
  // Stretch control and count of not-acknowledges
  input wire logic slow,
  output int nacks
);
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  int n = 0;
  logic in_addr = 1'b0;
  logic sending = 1'b0;

  initial begin
    scl_n = 1'b1;
    sda_n = 1'b1;
    nacks = 0;
  end

  // Start and stop, seen while the clock is high; looked at a moment
  // later, since data may move in the very step the clock falls
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1) begin
      n = 0;
      in_addr = 1'b1;
      sending = 1'b0;
      tx = FIRST;
    end
  end
  always @(posedge sda) begin
    #1;
    if (scl === 1'b1) begin
      in_addr = 1'b0;
      sending = 1'b0;
    end
  end

  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    if (n == 8 && sending && sda === 1'b1) begin
      sending = 1'b0;
      nacks = nacks + 1;
    end
    n = n + 1;
  end

  // Data changes only while the clock is low
  always @(negedge scl) begin
    if (n == 8) begin
      sda_n = !(in_addr && sh == {ADDR, 1'b1});
    end else if (n == 9) begin
      n = 0;
      if (in_addr) sending = !sda_n;
      else if (sending) tx = tx + 8'h01;
      in_addr = 1'b0;
      sda_n = sending ? tx[7] : 1'b1;
    end else if (sending && n > 0) begin
      sda_n = tx[3'(7 - n)];
    end
  end

  // Slow answer: hold the clock low after each falling edge
  always @(negedge scl) begin
    if (slow) begin
      scl_n = 1'b0;
      #1530;
      scl_n = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* dv/two_wire_master_receiver_tb.sv */
// Purpose: Self-checking bench for the two-wire master receiver
// Assumes: Rate count of 4 (low half bit of 5 clocks) keeps transfers short
// Notes: One slave transmitter model sits on the wires
`timescale 1ns/10ps
`default_nettype none
`include "two_wire_map.svh"

module two_wire_master_receiver_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [`REG_AW-1:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rv;
  wire logic [7:0] reg_rdata;
  wire logic irq, scl_level, scl_oe_n, sda_level, sda_oe_n, scl_n, sda_n;
  wire logic scl = scl_oe_n & scl_n;
  wire logic sda = sda_oe_n & sda_n;
  int nacks;
  int bad_count = 0;
  int compares = 0;

  always #50 mclk = ~mclk;

  two_wire_master_receiver #(.RATE_RST(4)) dut_u (
    .mclk, .resetn, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .scl_seen(scl), .scl_level, .scl_oe_n, .sda_seen(sda), .sda_level, .sda_oe_n
  );
  two_wire_slave_model slave_u (.scl, .sda, .scl_n, .sda_n, .slow, .nacks);

  // ----
  // Bus cycles and comparison
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic expect_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask

  task automatic wait_irq();
    int i;
    #1;
    for (i = 0; i < 3000 && irq !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (irq !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: no interrupt", $time);
      finish_test();
    end
  endtask

  // Write control, wait for the flag, judge status, clear the event
  task automatic step(input logic [7:0] ctrl, input logic [7:0] code);
    wr(`OFS_CTRL, ctrl);
    wait_irq();
    check({7'h00, scl_oe_n}, 8'h00);
    check({6'h00, scl_level, sda_level}, 8'h00);
    expect_reg(`OFS_STATUS, code);
    wr(`OFS_IRQ_STAT, 8'h01);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic test_reset_map();
    logic [7:0] exp [8];
    int i;
    exp = '{8'h00, 8'hF8, 8'hFF, 8'hFE, 8'h04, 8'h00, 8'h00, 8'h00};
    for (i = 0; i < 8; i++) expect_reg(3'(i), exp[i]);
    wr(`OFS_CTRL, 8'h02);
    expect_reg(`OFS_CTRL, 8'h00);
    wr(`OFS_OWN_ADDR, 8'hA5);
    expect_reg(`OFS_OWN_ADDR, 8'hA5);
    wr(`OFS_DATA, 8'h3C);
    expect_reg(`OFS_CTRL, 8'h08);
    expect_reg(`OFS_DATA, 8'hFF);
    $display("test reset_map done");
  endtask

  task automatic test_disabled();
    wr(`OFS_CTRL, 8'hA0);
    repeat (200) @(posedge mclk);
    expect_reg(`OFS_STATUS, 8'hF8);
    check({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    wr(`OFS_CTRL, 8'h00);
    $display("test disabled done");
  endtask

  task automatic test_receive();
    wr(`OFS_RATE, 8'h04);
    wr(`OFS_IRQ_MASK, 8'h05);
    step(8'hA4, 8'h08);
    wr(`OFS_DATA, 8'h55);
    step(8'hC4, 8'h40);
    step(8'hC4, 8'h50);
    expect_reg(`OFS_DATA, 8'h5C);
    slow <= 1'b1;
    step(8'h84, 8'h58);
    slow <= 1'b0;
    expect_reg(`OFS_DATA, 8'h5D);
    check(8'(nacks), 8'h01);
    step(8'hA4, 8'h10);
    wr(`OFS_DATA, 8'h23);
    step(8'hC4, 8'h48);
    step(8'hA4, 8'h10);
    wr(`OFS_DATA, 8'h54);
    step(8'hC4, 8'h20);
    step(8'hC4, 8'h30);
    $display("test receive done");
  endtask

  task automatic test_stop_irq();
    repeat (310) @(posedge mclk);
    check({7'h00, scl_oe_n}, 8'h00);
    wr(`OFS_CTRL, 8'h94);
    wait_irq();
    expect_reg(`OFS_IRQ_STAT, 8'h04);
    expect_reg(`OFS_STATUS, 8'hF8);
    expect_reg(`OFS_CTRL, 8'h04);
    wr(`OFS_IRQ_MASK, 8'h00);
    #1;
    check({7'h00, irq}, 8'h00);
    wr(`OFS_IRQ_STAT, 8'h04);
    wr(`OFS_IRQ_MASK, 8'h05);
    expect_reg(`OFS_IRQ_STAT, 8'h00);
    wr(`OFS_CTRL, 8'h00);
    $display("test stop_irq done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    test_reset_map();
    test_disabled();
    test_receive();
    test_stop_irq();
    finish_test();
  end
endmodule
`default_nettype wire
